// ==== shp_defines.svh ====
/*
  Constants of the serial host port: mode codes, trailer patterns, register
  positions of the option bits, reset values and clock figures.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef SHP_DEFINES_SVH
`define SHP_DEFINES_SVH

// ============================================================
// mode byte decoding
`define SHP_MODE_REG_WRITE 2'h0
`define SHP_MODE_REG_READ 2'h1
`define SHP_MODE_FIFO 2'h2
`define SHP_MODE_DIRECT_CMD 2'h3
`define SHP_TRAILER_FIFO_LOAD 6'h00
`define SHP_TRAILER_FIFO_READ 6'h3f
`define SHP_BYTE_LAST_BIT 3'h7

// ============================================================
// register positions of the bits the port itself uses
`define SHP_OPCTL_ADDR 6'h02
`define SHP_ENABLE_BIT 7
`define SHP_IOCFG2_ADDR 6'h01
`define SHP_PULLDOWN_A_BIT 3
`define SHP_PULLDOWN_B_BIT 4
`define SHP_REG_RESET_VALUE 8'h00

// ============================================================
// register presence and writability, one bit per address
`define SHP_REG_PRESENT_MASK 64'h0000_0000_ffff_ffff
`define SHP_REG_WRITABLE_MASK 64'h0000_0000_00ff_ffff

// ============================================================
// clock figures
`define SHP_CLK_PERIOD_NS 8
`define SHP_MCU_CLK_DIV 4'h2

`endif

// ==== shp_pkg.sv ====
/*
  Types of the serial host port: the port's state machine and its state record.
  Assumes shp_defines.svh is reachable by bare name.
*/
`include "shp_defines.svh"

package shp_pkg;

  // ============================================================
  // transaction states, one-hot
  typedef enum logic [5:0] {
    ST_MODE = 6'h01,
    ST_WR = 6'h02,
    ST_RD = 6'h04,
    ST_FLOAD = 6'h08,
    ST_FREAD = 6'h10,
    ST_IGNORE = 6'h20
  } shp_state_t;

  // ============================================================
  // whole state of the port engine
  typedef struct packed {
    shp_state_t st;
    logic [2:0] bits;
    logic [7:0] sh_in;
    logic [7:0] sh_out;
    logic [5:0] addr;
    logic [5:0] waddr;
    logic [1:0] pend;
    logic sclk_q;
    logic oe;
    logic miso;
    logic we;
    logic push;
    logic pop;
    logic cmd;
    logic irq;
    logic mcu_clk;
    logic [3:0] div;
  } shp_regs_t;

  // state of the two-flop synchroniser
  typedef struct packed {
    logic [2:0] stage1;
    logic [2:0] stage2;
  } shp_sync_t;

endpackage

// ==== shp_sync.sv ====
/*
  Two-flop synchroniser for the three inputs of the serial link.
  Assumes the inputs come from pins outside the i_clk domain.
*/
module shp_sync (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_async,
  output logic [2:0] o_sync
);

  shp_pkg::shp_sync_t r;
  shp_pkg::shp_sync_t next_r;

  // select resets high so the port starts idle
  always_comb begin
    next_r.stage1 = i_async;
    next_r.stage2 = r.stage1;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r <= {3'h4, 3'h4};
    end else begin
      r <= next_r;
    end
  end

  assign o_sync = r.stage2;

endmodule

// ==== shp_regfile.sv ====
/*
  The 64 byte-wide addressable registers behind the serial port.
  Assumes writes from the port and from device logic are one-cycle pulses.
*/
`include "shp_defines.svh"

module shp_regfile #(
  parameter logic [63:0] PRESENT_MASK = `SHP_REG_PRESENT_MASK,
  parameter logic [63:0] WRITABLE_MASK = `SHP_REG_WRITABLE_MASK
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_spi_we,
  input wire logic [5:0] i_spi_waddr,
  input wire logic [7:0] i_spi_wdata,
  input wire logic [5:0] i_spi_raddr,
  output logic [7:0] o_spi_rdata,
  input wire logic i_core_wr,
  input wire logic i_core_rd,
  input wire logic [5:0] i_core_addr,
  input wire logic [7:0] i_core_wdata,
  output logic [7:0] o_core_rdata,
  output logic [7:0] o_opctl,
  output logic [7:0] o_iocfg2
);

  // the storage array stands apart from a state record: it is a memory
  logic [7:0] mem [64];
  logic [7:0] core_rdata;

  // port writes only land on writable registers; device logic owns the rest
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int i = 0; i < 64; i++) begin
        mem[i] <= `SHP_REG_RESET_VALUE;
      end
      core_rdata <= `SHP_REG_RESET_VALUE;
    end else begin
      if (i_spi_we && WRITABLE_MASK[i_spi_waddr]) begin
        mem[i_spi_waddr] <= i_spi_wdata;
      end else if (i_core_wr && PRESENT_MASK[i_core_addr]) begin
        mem[i_core_addr] <= i_core_wdata;
      end
      if (i_core_rd) begin
        core_rdata <= PRESENT_MASK[i_core_addr] ? mem[i_core_addr] : 8'h00;
      end
    end
  end

  assign o_spi_rdata = PRESENT_MASK[i_spi_raddr] ? mem[i_spi_raddr] : 8'h00;
  assign o_core_rdata = core_rdata;
  assign o_opctl = mem[`SHP_OPCTL_ADDR];
  assign o_iocfg2 = mem[`SHP_IOCFG2_ADDR];

endmodule

// ==== shp_port.sv ====
/*
  Serial host port: a four-wire slave through which the microcontroller
  reads and writes the addressed registers, loads and drains the data FIFO
  and issues direct commands; also the interrupt and clock outputs.
  Assumes a first-word-fall-through FIFO on the device side whose read data
  follow a pop within one cycle, and a serial clock far slower than i_clk.
*/
// Design decisions made here: the plain strobed port and the placing of the registers.
// How it works
// - select high holds the port in reset; low enables it.
// - the input line is sampled on each falling serial clock edge.
// - transfers are bytes; first two bits after select falls give mode.
// - address and data move most significant bit first both ways.
// - mode 00 writes, 01 reads; six trailer bits hold the address.
// - each further data byte moves to the next address.
// - a written byte commits on the falling edge of its eighth bit.
// - a write byte cut short by select rising is dropped.
// - writes to absent or read-only addresses change nothing.
// - read bits go out on rising edges; the master samples on falling.
// - reading an absent address returns all zeros.
// - the output is released except while read data shift out.
// - a released output gets a pull-down if either option bit is set.
// - registers always work; FIFO access needs enable and stable oscillator.
// - mode 10 with zero trailer appends each following byte to the FIFO unless it is full.
// - a FIFO load byte cut short by select rising is not stored.
// - mode 10 with all-ones trailer shifts FIFO bytes out.
// - a FIFO byte not fully shifted out stays unread.
// - the port always drives an interrupt request, and drives a clock only while oscillating.
// - mode 11 runs the trailer as a command on the last falling edge.
`include "shp_defines.svh"

module shp_port #(
  parameter logic [63:0] PRESENT_MASK = `SHP_REG_PRESENT_MASK,
  parameter logic [63:0] WRITABLE_MASK = `SHP_REG_WRITABLE_MASK,
  parameter logic [3:0] MCU_CLK_DIV = `SHP_MCU_CLK_DIV
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ss_n,
  input wire logic i_sclk,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  output logic o_miso_pd,
  output logic o_irq,
  output logic o_mcu_clk,
  input wire logic i_irq_req,
  input wire logic i_osc_running,
  input wire logic i_osc_stable,
  output logic o_fifo_push,
  output logic [7:0] o_fifo_wdata,
  input wire logic i_fifo_full,
  output logic o_fifo_pop,
  input wire logic [7:0] i_fifo_rdata,
  input wire logic i_fifo_empty,
  output logic o_cmd_valid,
  output logic [5:0] o_cmd_code,
  input wire logic i_core_wr,
  input wire logic i_core_rd,
  input wire logic [5:0] i_core_addr,
  input wire logic [7:0] i_core_wdata,
  output logic [7:0] o_core_rdata
);

  // ============================================================
  // link inputs cross into i_clk
  logic [2:0] link_s;
  logic ss_s;
  logic sclk_s;
  logic mosi_s;

  shp_sync u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_ss_n, i_sclk, i_mosi}),
    .o_sync(link_s)
  );

  assign ss_s = link_s[2];
  assign sclk_s = link_s[1];
  assign mosi_s = link_s[0];

  // ============================================================
  // registers
  shp_pkg::shp_regs_t r;
  shp_pkg::shp_regs_t next_r;
  logic [7:0] reg_rdata;
  logic [7:0] opctl;
  logic [7:0] iocfg2;

  shp_regfile #(
    .PRESENT_MASK(PRESENT_MASK),
    .WRITABLE_MASK(WRITABLE_MASK)
  ) u_regs (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_spi_we(r.we),
    .i_spi_waddr(r.waddr),
    .i_spi_wdata(r.sh_in),
    .i_spi_raddr(r.addr),
    .o_spi_rdata(reg_rdata),
    .i_core_wr(i_core_wr),
    .i_core_rd(i_core_rd),
    .i_core_addr(i_core_addr),
    .i_core_wdata(i_core_wdata),
    .o_core_rdata(o_core_rdata),
    .o_opctl(opctl),
    .o_iocfg2(iocfg2)
  );

  // ============================================================
  // edge detection and decode helpers
  logic rise;
  logic fall;
  logic fifo_ok;
  logic byte_done;
  logic [7:0] in_byte;

  function automatic logic is_read_state(input shp_pkg::shp_state_t st);
    return (st == shp_pkg::ST_RD) || (st == shp_pkg::ST_FREAD);
  endfunction

  assign rise = sclk_s && !r.sclk_q;
  assign fall = !sclk_s && r.sclk_q;
  assign fifo_ok = opctl[`SHP_ENABLE_BIT] && i_osc_stable;
  assign byte_done = fall && !ss_s && (r.bits == `SHP_BYTE_LAST_BIT);
  assign in_byte = {r.sh_in[6:0], mosi_s};

  // ============================================================
  // port engine
  always_comb begin
    next_r = r;
    next_r.sclk_q = sclk_s;
    next_r.we = 1'b0;
    next_r.push = 1'b0;
    next_r.pop = 1'b0;
    next_r.cmd = 1'b0;
    next_r.irq = i_irq_req;
    if (r.div == MCU_CLK_DIV - 4'h1) begin
      next_r.div = 4'h0;
      next_r.mcu_clk = i_osc_running ? !r.mcu_clk : 1'b0;
    end else begin
      next_r.div = r.div + 4'h1;
    end
    if (ss_s) begin
      // partial bytes die here: no commit, no push, no pop
      next_r.st = shp_pkg::ST_MODE;
      next_r.bits = 3'h0;
      next_r.oe = 1'b0;
      next_r.pend = 2'h0;
    end else begin
      if (r.pend != 2'h0) begin
        next_r.pend = r.pend - 2'h1;
      end
      // the pop takes a cycle to show, so the load waits two
      if (r.pend == 2'h1) begin
        if (r.st == shp_pkg::ST_FREAD) begin
          next_r.sh_out = i_fifo_empty ? 8'h00 : i_fifo_rdata;
        end else begin
          next_r.sh_out = reg_rdata;
        end
      end
      if (rise && is_read_state(r.st)) begin
        next_r.oe = 1'b1;
        next_r.miso = r.sh_out[3'h7 - r.bits];
      end
      if (fall) begin
        next_r.sh_in = in_byte;
        next_r.bits = r.bits + 3'h1;
      end
      if (byte_done) begin
        unique case (r.st)
          shp_pkg::ST_MODE: begin
            unique case (in_byte[7:6])
              `SHP_MODE_REG_WRITE: begin
                next_r.st = shp_pkg::ST_WR;
                next_r.addr = in_byte[5:0];
              end
              `SHP_MODE_REG_READ: begin
                next_r.st = shp_pkg::ST_RD;
                next_r.addr = in_byte[5:0];
                next_r.pend = 2'h2;
              end
              `SHP_MODE_FIFO: begin
                if (fifo_ok && in_byte[5:0] == `SHP_TRAILER_FIFO_LOAD) begin
                  next_r.st = shp_pkg::ST_FLOAD;
                end else if (fifo_ok && in_byte[5:0] == `SHP_TRAILER_FIFO_READ) begin
                  next_r.st = shp_pkg::ST_FREAD;
                  next_r.pend = 2'h2;
                end else begin
                  next_r.st = shp_pkg::ST_IGNORE;
                end
              end
              `SHP_MODE_DIRECT_CMD: begin
                // stays in mode state so a chained transaction can follow
                next_r.cmd = 1'b1;
              end
            endcase
          end
          shp_pkg::ST_WR: begin
            // the write lands in the register file one cycle after this
            next_r.we = 1'b1;
            next_r.waddr = r.addr;
            next_r.addr = r.addr + 6'h01;
          end
          shp_pkg::ST_RD: begin
            next_r.addr = r.addr + 6'h01;
            next_r.pend = 2'h2;
          end
          shp_pkg::ST_FLOAD: begin
            // a full FIFO drops the byte; the bench FIFO holds 96
            next_r.push = !i_fifo_full;
          end
          shp_pkg::ST_FREAD: begin
            next_r.pop = !i_fifo_empty;
            next_r.pend = 2'h2;
          end
          shp_pkg::ST_IGNORE: begin
            next_r.st = shp_pkg::ST_IGNORE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r <= '{
        st: shp_pkg::ST_MODE,
        bits: 3'h0,
        sh_in: 8'h00,
        sh_out: 8'h00,
        addr: 6'h00,
        waddr: 6'h00,
        pend: 2'h0,
        sclk_q: 1'b0,
        oe: 1'b0,
        miso: 1'b0,
        we: 1'b0,
        push: 1'b0,
        pop: 1'b0,
        cmd: 1'b0,
        irq: 1'b0,
        mcu_clk: 1'b0,
        div: 4'h0
      };
    end else begin
      r <= next_r;
    end
  end

  // ============================================================
  // outputs
  assign o_miso = r.oe ? r.miso : 1'b0;
  assign o_miso_oe = r.oe;
  assign o_miso_pd = !r.oe && (iocfg2[`SHP_PULLDOWN_A_BIT] ||
                     iocfg2[`SHP_PULLDOWN_B_BIT]);
  assign o_irq = r.irq;
  assign o_mcu_clk = r.mcu_clk;
  assign o_fifo_push = r.push;
  assign o_fifo_wdata = r.sh_in;
  assign o_fifo_pop = r.pop;
  assign o_cmd_valid = r.cmd;
  assign o_cmd_code = r.sh_in[5:0];

  // ============================================================
  // checks
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  ss_reset_a: assert property (ss_s |=> !o_miso_oe && r.bits == 3'h0 &&
      r.st == shp_pkg::ST_MODE)
    else $error("port not held idle while select is high");

  fall_sample_a: assert property ((fall && !ss_s) |=> r.sh_in[0] == $past(mosi_s))
    else $error("input bit not taken on falling edge");

  byte_wrap_a: assert property (byte_done |=> r.bits == 3'h0)
    else $error("bit counter did not wrap after eight bits");

  msb_first_a: assert property ((rise && !ss_s && is_read_state(r.st) &&
      r.bits == 3'h0) |=> o_miso_oe && o_miso == $past(r.sh_out[7]))
    else $error("read byte did not start with its top bit");

  auto_inc_a: assert property (r.we |-> r.addr == r.waddr + 6'h01)
    else $error("address did not advance after a write");

  write_commit_a: assert property ((byte_done && r.st == shp_pkg::ST_WR) |=>
      r.we ##1 !r.we)
    else $error("write byte not committed on its eighth falling edge");

  partial_drop_a: assert property (ss_s |=> !r.we && !r.push && !r.pop)
    else $error("partial byte acted on after select rose");

  out_release_a: assert property (o_miso_oe |-> is_read_state(r.st))
    else $error("output driven outside read data");

  pulldown_a: assert property ((!o_miso_oe && iocfg2[`SHP_PULLDOWN_B_BIT])
      |-> o_miso_pd)
    else $error("pull-down missing on released output");

  fifo_gate_a: assert property (($past(r.st) == shp_pkg::ST_MODE &&
      (r.st == shp_pkg::ST_FLOAD || r.st == shp_pkg::ST_FREAD)) |-> $past(fifo_ok))
    else $error("FIFO transaction entered while FIFO access is off");

  fifo_pop_a: assert property (r.pop |-> $past(fall) &&
      $past(r.bits) == `SHP_BYTE_LAST_BIT && $past(r.st) == shp_pkg::ST_FREAD)
    else $error("FIFO byte popped before fully shifted out");

  cmd_exec_a: assert property (r.cmd |-> $past(r.st) == shp_pkg::ST_MODE &&
      r.st == shp_pkg::ST_MODE)
    else $error("direct command issued outside a mode byte");

  miso_hold_a: assert property ($changed(r.miso) |-> $past(rise))
    else $error("output bit changed away from a rising serial clock edge");

  oe_first_a: assert property ($rose(o_miso_oe) |-> $past(rise) &&
      ($past(r.st) == shp_pkg::ST_RD || $past(r.st) == shp_pkg::ST_FREAD))
    else $error("output enabled outside a read data edge");

  absent_zero_a: assert property ((!ss_s && r.pend == 2'h1 &&
      r.st == shp_pkg::ST_RD && !PRESENT_MASK[r.addr]) |=> r.sh_out == 8'h00)
    else $error("absent register did not read as zero");

  push_full_a: assert property (r.push |-> $past(byte_done) &&
      $past(r.st) == shp_pkg::ST_FLOAD && !$past(i_fifo_full))
    else $error("FIFO push without a complete load byte");

  cmd_last_a: assert property (r.cmd |-> $past(byte_done))
    else $error("direct command issued before its last falling edge");

  mode_clear_a: assert property ($fell(ss_s) |-> r.bits == 3'h0 &&
      r.st == shp_pkg::ST_MODE)
    else $error("counters not cleared when select fell");

  irq_follow_a: assert property (!i_rst |=> o_irq == $past(i_irq_req))
    else $error("interrupt output does not follow the request");

  mcu_clk_idle_a: assert property ((!i_osc_running &&
      r.div == MCU_CLK_DIV - 4'h1) |=> !o_mcu_clk)
    else $error("clock output kept running without the oscillator");

endmodule

// ==== shp_mcu_model.sv ====
/*
  Bus master partner of the serial host port: drives select, serial clock
  and data in, and samples the resolved data line on falling clock edges.
  Assumes i_clk is the device clock and i_miso the resolved wire level.
*/
module shp_mcu_model (
  input wire logic i_clk,
  input wire logic i_miso,
  output logic o_ss_n,
  output logic o_sclk,
  output logic o_mosi
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    o_ss_n = 1'b1;
    o_sclk = 1'b0;
    o_mosi = 1'b0;
  end

  // ============================================================
  // framing; the long gaps cover the select set-up and hold times
  task automatic sel(input logic on);
    repeat (40) @(posedge i_clk);
    o_ss_n <= ~on;
    // a released data line flips so a stale bit never passes for a driven one
    if (!on) o_mosi <= ~o_mosi;
    repeat (40) @(posedge i_clk);
  endtask

  // one byte msb first; nbits below 8 cuts the byte short
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < nbits; i++) begin
      @(posedge i_clk);
      o_sclk <= 1'b1;
      o_mosi <= tx[7 - i];
      repeat (5) @(posedge i_clk);
      o_sclk <= 1'b0;
      rx = {rx[6:0], i_miso};
      repeat (4) @(posedge i_clk);
    end
  endtask
endmodule

// ==== spi_slave_host_port_tb.sv ====
/*
  Self-checking bench of the serial host port: a master model drives the link,
  the bench plays the device fifo and keeps a register model.
  Assumes shp_port with its default parameters and a 125 MHz clock.
*/
`include "shp_defines.svh"

module spi_slave_host_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic ss_n, sclk, mosi, miso_wire, irq_q, rst_q, i_irq_req, i_osc_running, i_osc_stable;
  logic o_miso, o_miso_oe, o_miso_pd, o_irq, o_mcu_clk, o_fifo_push, o_fifo_pop, o_cmd_valid;
  logic fifo_full, fifo_empty, i_core_wr, i_core_rd;
  logic [7:0] o_fifo_wdata, o_core_rdata, fifo_rdata, i_core_wdata, rx, d, last_cmd;
  logic [5:0] o_cmd_code, i_core_addr, code;
  logic [63:0] wmask = `SHP_REG_WRITABLE_MASK;
  logic [63:0] pmask = `SHP_REG_PRESENT_MASK;
  logic [7:0] fifo_q[$];
  logic [7:0] exp_q[$];
  logic [7:0] exp_reg[64];
  int n_mismatch = 0;
  int checked = 0;
  int seed = 32'had52;
  int toggles;
  // oscillator inputs run random until the FIFO phase, then follow osc_set
  logic osc_rnd = 1'b1;
  logic [1:0] osc_set = 2'b00;

  always #4 i_clk = ~i_clk;
  assign miso_wire = o_miso_oe ? o_miso : (o_miso_pd ? 1'b0 : 1'b1);

  shp_port u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_ss_n(ss_n), .i_sclk(sclk), .i_mosi(mosi),
    .o_miso(o_miso), .o_miso_oe(o_miso_oe), .o_miso_pd(o_miso_pd), .o_irq(o_irq),
    .o_mcu_clk(o_mcu_clk), .i_irq_req(i_irq_req), .i_osc_running(i_osc_running),
    .i_osc_stable(i_osc_stable), .o_fifo_push(o_fifo_push), .o_fifo_wdata(o_fifo_wdata),
    .i_fifo_full(fifo_full), .o_fifo_pop(o_fifo_pop), .i_fifo_rdata(fifo_rdata),
    .i_fifo_empty(fifo_empty), .o_cmd_valid(o_cmd_valid), .o_cmd_code(o_cmd_code),
    .i_core_wr(i_core_wr), .i_core_rd(i_core_rd), .i_core_addr(i_core_addr),
    .i_core_wdata(i_core_wdata), .o_core_rdata(o_core_rdata));
  shp_mcu_model u_mcu (.i_clk(i_clk), .i_miso(miso_wire), .o_ss_n(ss_n), .o_sclk(sclk),
    .o_mosi(mosi));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("mismatches %0d, checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ============================================================
  // device side: fall-through fifo, command capture, irq follower
  always @(posedge i_clk) begin
    if (o_fifo_push && fifo_q.size() < 96) fifo_q.push_back(o_fifo_wdata);
    if (o_fifo_pop && fifo_q.size() > 0) void'(fifo_q.pop_front());
    if (o_cmd_valid) last_cmd = {2'b01, o_cmd_code};
    if (!i_rst && !rst_q) chk({7'h00, o_irq}, {7'h00, irq_q});
    fifo_full <= fifo_q.size() >= 96;
    fifo_empty <= fifo_q.size() == 0;
    fifo_rdata <= fifo_q.size() > 0 ? fifo_q[0] : 8'h00;
    rst_q <= i_rst;
    irq_q <= i_irq_req;
    i_irq_req <= 1'($random(seed));
    {i_osc_running, i_osc_stable} <= osc_rnd ? 2'($random(seed)) : osc_set;
  end

  // ============================================================
  // transactions
  function automatic logic [7:0] exp_rd(input logic [5:0] a);
    return pmask[a] ? exp_reg[a] : 8'h00;
  endfunction

  task automatic spi_wr(input logic [5:0] a, input int n, input logic [7:0] first);
    logic [7:0] v;
    logic [5:0] k;
    u_mcu.sel(1'b1);
    u_mcu.xfer({2'b00, a}, 8, v);
    for (int i = 0; i < n; i++) begin
      v = (i == 0) ? first : 8'($random(seed));
      k = a + 6'(i);
      u_mcu.xfer(v, 8, d);
      if (wmask[k]) exp_reg[k] = v;
    end
    u_mcu.sel(1'b0);
  endtask

  task automatic spi_rd(input logic [5:0] a, input int n);
    logic [7:0] v;
    u_mcu.sel(1'b1);
    u_mcu.xfer({2'b01, a}, 8, v);
    for (int i = 0; i < n; i++) begin
      u_mcu.xfer(8'($random(seed)), 8, v);
      chk(v, exp_rd(a + 6'(i)));
    end
    u_mcu.sel(1'b0);
    chk({7'h00, o_miso_oe}, 8'h00);
  endtask

  task automatic fifo_ld(input int n, input logic keep);
    logic [7:0] v;
    u_mcu.sel(1'b1);
    u_mcu.xfer(8'h80, 8, v);
    for (int i = 0; i < n; i++) begin
      v = 8'($random(seed));
      u_mcu.xfer(v, 8, d);
      if (keep) exp_q.push_back(v);
    end
    u_mcu.xfer(8'h5a, 5, d);
    u_mcu.sel(1'b0);
  endtask

  task automatic fifo_rd(input int n, input int cut);
    logic [7:0] v;
    u_mcu.sel(1'b1);
    u_mcu.xfer(8'hbf, 8, v);
    for (int i = 0; i < n; i++) begin
      u_mcu.xfer(8'h00, 8, v);
      chk(v, exp_q.pop_front());
    end
    if (cut > 0) u_mcu.xfer(8'h00, cut, v);
    u_mcu.sel(1'b0);
  endtask

  task automatic core_rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_core_rd <= 1'b1;
    i_core_addr <= a;
    @(posedge i_clk);
    i_core_rd <= 1'b0;
    @(negedge i_clk);
    chk(o_core_rdata, exp);
  endtask

  // ============================================================
  // main sequence
  initial begin
    {i_core_wr, i_core_rd, i_core_addr, i_core_wdata, last_cmd} = 24'h00_0000;
    foreach (exp_reg[k]) exp_reg[k] = `SHP_REG_RESET_VALUE;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_clk);
    spi_wr(6'h16, 3, 8'h3c);
    spi_wr(6'h3f, 2, 8'ha5);
    u_mcu.sel(1'b1);
    u_mcu.xfer(8'h05, 8, d);
    u_mcu.xfer(8'hff, 6, d);
    u_mcu.sel(1'b0);
    @(posedge i_clk);
    d = 8'($random(seed));
    i_core_wr <= 1'b1;
    i_core_addr <= 6'h10;
    i_core_wdata <= d;
    exp_reg[16] = d;
    @(posedge i_clk);
    i_core_wr <= 1'b0;
    spi_rd(6'h15, 4);
    spi_rd(6'h3f, 2);
    spi_rd(6'h04, 2);
    spi_rd(6'h0f, 2);
    spi_rd(6'h1f, 2);
    for (int i = 0; i < 4; i++) begin
      spi_wr(6'h01, 1, {3'h0, i[1:0], 3'h0});
      chk({7'h00, o_miso_pd}, {7'h00, i != 0});
    end
    osc_rnd <= 1'b0;
    osc_set <= 2'b01;
    fifo_ld(2, 1'b0); // enable bit still clear
    chk(8'(fifo_q.size()), 8'h00);
    spi_wr(6'h02, 1, 8'h80);
    osc_set <= 2'b00;
    fifo_ld(2, 1'b0); // oscillator not stable
    chk(8'(fifo_q.size()), 8'h00);
    osc_set <= 2'b01;
    fifo_ld(3, 1'b1);
    chk(8'(fifo_q.size()), 8'h03);
    fifo_rd(1, 3);
    fifo_rd(2, 0);
    for (int i = 0; i < 4; i++) begin
      code = 6'($random(seed));
      last_cmd = 8'h00;
      u_mcu.sel(1'b1);
      u_mcu.xfer({2'b11, code}, 8, d);
      u_mcu.xfer(8'h56, 8, d);
      u_mcu.xfer(8'h00, 8, rx);
      u_mcu.sel(1'b0);
      chk(rx, exp_reg[22]);
      chk(last_cmd, {2'b01, code});
    end
    osc_set <= 2'b11;
    repeat (8) @(negedge i_clk);
    toggles = 0;
    for (int i = 0; i < 16; i++) begin
      d[0] = o_mcu_clk;
      @(negedge i_clk);
      if (o_mcu_clk !== d[0]) toggles++;
    end
    chk(8'(toggles), 8'(16 / `SHP_MCU_CLK_DIV));
    osc_set <= 2'b01;
    repeat (6) @(posedge i_clk);
    chk({7'h00, o_mcu_clk}, 8'h00);
    for (int i = 0; i < 64; i++)
      if (pmask[i]) core_rd(6'(i), exp_rd(6'(i)));
    end_of_test();
  end

  initial begin
    repeat (100000) @(posedge i_clk);
    n_mismatch++;
    end_of_test();
  end
endmodule
